// ### walk_base_pkg.sv
/*
 * Constants for the walk base selection block: coprocessor register
 * selectors, field positions, reset values and attribute encodings.
 * Assumes a 32-bit coprocessor data path and 32-bit virtual addresses.
 */
package walk_base_pkg;

    localparam int unsigned ADDR_W          = 32;
    localparam int unsigned BOUND_W         = 3;
    localparam int unsigned LOW_BASE_LSB    = 7;
    localparam int unsigned HIGH_BASE_LSB   = 14;
    localparam int unsigned ATTR_W          = 7;
    localparam int unsigned CTRL_W          = 6;

    // Coprocessor register selection
    localparam logic [3:0]  SEL_CRN         = 4'h2;
    localparam logic [3:0]  SEL_CRM         = 4'h0;
    localparam logic [2:0]  SEL_OPC2_LOW    = 3'h0;
    localparam logic [2:0]  SEL_OPC2_HIGH   = 3'h1;
    localparam logic [2:0]  SEL_OPC2_CTRL   = 3'h2;

    // Base register attribute bits
    localparam int unsigned INNER_LO_BIT    = 6;
    localparam int unsigned OUTER_HI_BIT    = 4;
    localparam int unsigned OUTER_LO_BIT    = 3;
    localparam int unsigned SHARED_BIT      = 1;
    localparam int unsigned INNER_HI_BIT    = 0;
    localparam logic [6:0]  ATTR_MASK       = 7'h5b;

    // Control register fields
    localparam int unsigned HIGH_DIS_BIT    = 5;
    localparam int unsigned LOW_DIS_BIT     = 4;
    localparam int unsigned BOUND_HI        = 2;
    localparam int unsigned BOUND_LO        = 0;
    localparam logic [5:0]  CTRL_MASK       = 6'h37;
    localparam logic [5:0]  CTRL_RESET      = 6'h00;
    localparam logic [2:0]  BOUND_ZERO      = 3'h0;

    // Bank index: one copy per security state
    localparam logic        BANK_SECURE     = 1'b1;

    // Inner and outer cacheability codes
    localparam logic [1:0]  CACHE_NONE      = 2'h0;
    localparam logic [1:0]  CACHE_WB_ALLOC  = 2'h1;
    localparam logic [1:0]  CACHE_WT        = 2'h2;
    localparam logic [1:0]  CACHE_WB_NOALLOC = 2'h3;

endpackage : walk_base_pkg

// ### walk_select_if.sv
/*
 * Bundle between the register holder and the region selector.
 * Assumes both ends sit in the same clock domain; the path is combinational.
 */
`timescale 1ns/1ps
interface walk_select_if;
    logic [2:0]  boundary;
    logic [31:0] va;
    logic [31:0] low_base;
    logic [31:0] high_base;
    logic        use_high;
    logic [31:0] walk_base;

    modport holder   (output boundary, output va, output low_base, output high_base,
                      input use_high, input walk_base);
    modport selector (input boundary, input va, input low_base, input high_base,
                      output use_high, output walk_base);
endinterface : walk_select_if

// ### walk_region_select.sv
/*
 * Chooses the low or high region base for a missed virtual address and
 * trims the low region base to the width allowed by the boundary field.
 * Assumes the bases arrive with their unused low bits already zero.
 */
`timescale 1ns/1ps
module walk_region_select
(
    walk_select_if.selector sel
);

    logic [31:0] top_bits;
    logic [31:0] low_keep;

    ////////////////////////////////////////////////////////////////////////////
    genvar i;
    generate
        for (i = 0; i < walk_base_pkg::ADDR_W; i++)
        begin : g_bit
            assign top_bits[i] = ((i + int'(sel.boundary)) >= int'(walk_base_pkg::ADDR_W))
                                 ? sel.va[i] : 1'b0;
            // walk uses upper base bits only
            assign low_keep[i] = ((i + int'(sel.boundary))
                                  >= int'(walk_base_pkg::HIGH_BASE_LSB))
                                 ? sel.low_base[i] : 1'b0;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // zero boundary always low
    // any top bit set picks high
    assign sel.use_high  = (sel.boundary != walk_base_pkg::BOUND_ZERO) && (top_bits != 32'h0);
    assign sel.walk_base = sel.use_high ? sel.high_base : low_keep;

endmodule : walk_region_select

// ### walk_base_select.sv
/*
 * Walk base registers and walk base selection for the memory management
 * unit: banked high/low region bases and control register reached by
 * coprocessor accesses, and a registered walk setup on every TLB miss.
 * Assumes one-cycle request strobes synchronous to i_ref_clk and that the
 * core turns o_cp_undef into an Undefined instruction exception.
 */
// Behaviour
// - Privileged access only, banked per security state
// - High base bits 31:14 hold table pointer
// - High write takes pointer from bits 31:14
// - Two-bit outer attribute marks walk accesses
// - Shared bit directs walks to shared memory
// - Inner attribute from bits 0 and 6
// - Only write-back inner looks up data cache
// - Selectors c2,c0 opcode 0, 1 and 2
// - Miss takes base from selected register
// - Locked secure control write is undefined
// - Only secure control copy resets to zero
// - High disable gives section translation fault
// - Low disable gives section translation fault
// - Enabled walk uses current security privilege
// - Boundary field sets low table size
// - Zero boundary always selects low base
// - Nonzero boundary selects by top bits
// - Low base stores bits 31:7, reads all
`timescale 1ns/1ps
module walk_base_select
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    input  wire logic        i_cp_valid,
    input  wire logic        i_cp_write,
    input  wire logic [3:0]  i_cp_crn,
    input  wire logic [3:0]  i_cp_crm,
    input  wire logic [2:0]  i_cp_opc2,
    input  wire logic [31:0] i_cp_wdata,
    input  wire logic        i_cp_priv,
    input  wire logic        i_cp_secure,
    input  wire logic        i_secure_cfg_write_lock,
    output logic             o_cp_ack,
    output logic [31:0]      o_cp_rdata,
    output logic             o_cp_undef,
    input  wire logic        i_miss_valid,
    input  wire logic [31:0] i_miss_virtual_address,
    input  wire logic        i_miss_secure,
    output logic             o_walk_valid,
    output logic [31:0]      o_walk_base,
    output logic             o_walk_use_high,
    output logic             o_walk_fault,
    output logic             o_walk_secure,
    output logic [1:0]       o_walk_outer_attr,
    output logic [1:0]       o_walk_inner_attr,
    output logic             o_walk_shared,
    output logic             o_walk_dcache_lookup
);

    // Banked storage, index 1 is the Secure copy
    logic [31:7]  low_base_q  [2];
    logic [6:0]   low_attr_q  [2];
    logic [31:14] high_base_q [2];
    logic [6:0]   high_attr_q [2];
    logic [5:0]   ctrl_q      [2];

    logic         hit_sel;
    logic         is_low;
    logic         is_high;
    logic         is_ctrl;
    logic         access_ok;
    logic         ctrl_locked;
    logic         do_write;
    logic [31:0]  rdata_d;
    logic [5:0]   miss_ctrl;
    logic [6:0]   miss_attr;
    logic         miss_dis;

    walk_select_if sel_if ();

    walk_region_select u_region_select
    (
        .sel (sel_if.selector)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Request decode
    // coprocessor register selection
    assign hit_sel  = (i_cp_crn == walk_base_pkg::SEL_CRN) && (i_cp_crm == walk_base_pkg::SEL_CRM);
    assign is_low   = hit_sel && (i_cp_opc2 == walk_base_pkg::SEL_OPC2_LOW);
    assign is_high  = hit_sel && (i_cp_opc2 == walk_base_pkg::SEL_OPC2_HIGH);
    assign is_ctrl  = hit_sel && (i_cp_opc2 == walk_base_pkg::SEL_OPC2_CTRL);
    // user mode never reaches the registers
    assign access_ok = i_cp_priv && (is_low || is_high || is_ctrl);
    // lock only blocks Secure control writes
    assign ctrl_locked = is_ctrl && i_cp_write && i_cp_secure && i_secure_cfg_write_lock;
    assign do_write  = i_cp_valid && i_cp_write && access_ok && !ctrl_locked;

    ////////////////////////////////////////////////////////////////////////////
    // Base register writes; bases hold no documented reset, cleared here for safety
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            low_base_q[0]  <= '0;
            low_base_q[1]  <= '0;
            low_attr_q[0]  <= '0;
            low_attr_q[1]  <= '0;
            high_base_q[0] <= '0;
            high_base_q[1] <= '0;
            high_attr_q[0] <= '0;
            high_attr_q[1] <= '0;
        end
        else if (do_write && is_low)
        begin
            low_base_q[i_cp_secure] <= i_cp_wdata[31:walk_base_pkg::LOW_BASE_LSB];
            low_attr_q[i_cp_secure] <= i_cp_wdata[6:0] & walk_base_pkg::ATTR_MASK;
        end
        else if (do_write && is_high)
        begin
            // pointer from bits 31:14, 13:7 dropped
            high_base_q[i_cp_secure] <= i_cp_wdata[31:walk_base_pkg::HIGH_BASE_LSB];
            high_attr_q[i_cp_secure] <= i_cp_wdata[6:0] & walk_base_pkg::ATTR_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Secure control copy resets to zero
    // Non-secure copy has no reset; software must program it before use
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            ctrl_q[walk_base_pkg::BANK_SECURE] <= walk_base_pkg::CTRL_RESET;
        end
        else if (do_write && is_ctrl)
        begin
            ctrl_q[i_cp_secure] <= i_cp_wdata[5:0] & walk_base_pkg::CTRL_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data; reserved bits read as zero
    always_comb
    begin
        rdata_d = 32'h0;
        if (is_low)
        begin
            rdata_d = {low_base_q[i_cp_secure], low_attr_q[i_cp_secure]};
        end
        else if (is_high)
        begin
            rdata_d = {high_base_q[i_cp_secure], 7'h00, high_attr_q[i_cp_secure]};
        end
        else if (is_ctrl)
        begin
            rdata_d = {26'h0, ctrl_q[i_cp_secure]};
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            o_cp_ack   <= 1'b0;
            o_cp_undef <= 1'b0;
            o_cp_rdata <= 32'h0;
        end
        else
        begin
            o_cp_ack   <= i_cp_valid;
            o_cp_undef <= i_cp_valid && (!access_ok || ctrl_locked);
            o_cp_rdata <= (i_cp_valid && !i_cp_write && access_ok) ? rdata_d : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Walk setup on a TLB miss
    // bank of the missing access
    assign miss_ctrl        = ctrl_q[i_miss_secure];
    assign sel_if.boundary  = miss_ctrl[walk_base_pkg::BOUND_HI:walk_base_pkg::BOUND_LO];
    assign sel_if.va        = i_miss_virtual_address;
    assign sel_if.low_base  = {low_base_q[i_miss_secure], 7'h00};
    assign sel_if.high_base = {high_base_q[i_miss_secure], 14'h0000};
    assign miss_attr = sel_if.use_high ? high_attr_q[i_miss_secure] : low_attr_q[i_miss_secure];
    assign miss_dis  = sel_if.use_high ? miss_ctrl[walk_base_pkg::HIGH_DIS_BIT]
                                       : miss_ctrl[walk_base_pkg::LOW_DIS_BIT];

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            o_walk_valid         <= 1'b0;
            o_walk_base          <= 32'h0;
            o_walk_use_high      <= 1'b0;
            o_walk_fault         <= 1'b0;
            o_walk_secure        <= 1'b0;
            o_walk_outer_attr    <= walk_base_pkg::CACHE_NONE;
            o_walk_inner_attr    <= walk_base_pkg::CACHE_NONE;
            o_walk_shared        <= 1'b0;
            o_walk_dcache_lookup <= 1'b0;
        end
        else
        begin
            o_walk_valid    <= i_miss_valid;
            o_walk_base     <= sel_if.walk_base;
            o_walk_use_high <= sel_if.use_high;
            o_walk_fault    <= i_miss_valid && miss_dis;
            o_walk_secure   <= i_miss_secure;
            o_walk_outer_attr <= miss_attr[walk_base_pkg::OUTER_HI_BIT:walk_base_pkg::OUTER_LO_BIT];
            o_walk_inner_attr <= {miss_attr[walk_base_pkg::INNER_HI_BIT],
                                  miss_attr[walk_base_pkg::INNER_LO_BIT]};
            o_walk_shared   <= miss_attr[walk_base_pkg::SHARED_BIT];
            o_walk_dcache_lookup <= miss_attr[walk_base_pkg::INNER_LO_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    logic       exp_high;
    logic [2:0] exp_bound;
    assign exp_bound = miss_ctrl[walk_base_pkg::BOUND_HI:walk_base_pkg::BOUND_LO];
    assign exp_high  = (exp_bound != walk_base_pkg::BOUND_ZERO)
                       && ((i_miss_virtual_address >> (6'd32 - {3'h0, exp_bound})) != 32'h0);
    logic [6:0]  exp_attr;
    logic [31:0] exp_low;
    assign exp_attr = exp_high ? high_attr_q[i_miss_secure] : low_attr_q[i_miss_secure];
    assign exp_low  = {low_base_q[i_miss_secure], 7'h00}
                      & (32'hffff_ffff << (5'd14 - {2'h0, exp_bound}));

    sequence s_locked_ctrl_write;
        i_cp_valid && ctrl_locked && i_cp_priv;
    endsequence

    sequence s_high_write;
        i_cp_valid && i_cp_write && is_high && i_cp_priv;
    endsequence

    sequence s_high_read_same;
        i_cp_valid && !i_cp_write && is_high && i_cp_priv
            && (i_cp_secure == $past(i_cp_secure, 2));
    endsequence

    sequence s_low_write;
        i_cp_valid && i_cp_write && is_low && i_cp_priv;
    endsequence

    sequence s_low_read_same;
        i_cp_valid && !i_cp_write && is_low && i_cp_priv
            && (i_cp_secure == $past(i_cp_secure, 2));
    endsequence

    chk_locked_write_undef: assert property (
        s_locked_ctrl_write |=> o_cp_ack && o_cp_undef)
        else $error("locked control write not refused");

    chk_locked_write_keep: assert property (
        s_locked_ctrl_write |=> ctrl_q[walk_base_pkg::BANK_SECURE]
                                == $past(ctrl_q[walk_base_pkg::BANK_SECURE]))
        else $error("locked control write changed register");

    chk_user_mode_refused: assert property (
        i_cp_valid && !i_cp_priv |=> o_cp_undef && (o_cp_rdata == 32'h0))
        else $error("user mode access not refused");

    chk_high_write_read: assert property (
        s_high_write ##1 !i_cp_valid ##1 s_high_read_same
            |=> o_cp_rdata[31:14] == $past(i_cp_wdata[31:14], 3) && o_cp_rdata[13:7] == 7'h00)
        else $error("high base pointer not returned");

    chk_secure_ctrl_reset: assert property (
        $past(i_rst) |-> ctrl_q[walk_base_pkg::BANK_SECURE] == walk_base_pkg::CTRL_RESET)
        else $error("secure control copy not reset");

    chk_region_choice: assert property (
        i_miss_valid |=> o_walk_valid && (o_walk_use_high == $past(exp_high)))
        else $error("wrong region selected");

    chk_zero_bound_low: assert property (
        i_miss_valid && exp_bound == walk_base_pkg::BOUND_ZERO |=> !o_walk_use_high)
        else $error("zero boundary chose high region");

    chk_high_disable: assert property (
        i_miss_valid && exp_high && miss_ctrl[walk_base_pkg::HIGH_DIS_BIT] |=> o_walk_fault)
        else $error("high region walk not disabled");

    chk_low_disable: assert property (
        i_miss_valid && !exp_high |=> o_walk_fault == $past(miss_ctrl[walk_base_pkg::LOW_DIS_BIT]))
        else $error("low region disable wrong");

    chk_dcache_lookup: assert property (
        o_walk_valid |-> o_walk_dcache_lookup == (o_walk_inner_attr == walk_base_pkg::CACHE_WB_ALLOC
                                || o_walk_inner_attr == walk_base_pkg::CACHE_WB_NOALLOC))
        else $error("data cache lookup on non write-back");

    chk_walk_privilege: assert property (
        i_miss_valid ##1 o_walk_valid |-> o_walk_secure == $past(i_miss_secure))
        else $error("walk privilege does not follow state");

    chk_cp_answer: assert property (
        i_cp_valid |=> o_cp_ack)
        else $error("coprocessor access not answered");

    chk_cp_quiet: assert property (
        !i_cp_valid |=> !o_cp_ack && !o_cp_undef && o_cp_rdata == 32'h0)
        else $error("answer without a request");

    chk_bad_selector: assert property (
        i_cp_valid && (i_cp_crn != walk_base_pkg::SEL_CRN || i_cp_crm != walk_base_pkg::SEL_CRM
                       || i_cp_opc2 > walk_base_pkg::SEL_OPC2_CTRL)
            |=> o_cp_undef && o_cp_rdata == 32'h0)
        else $error("unmapped selector not refused");

    chk_ns_ctrl_write: assert property (
        i_cp_valid && i_cp_write && i_cp_priv && !i_cp_secure && is_ctrl
            |=> !o_cp_undef && ctrl_q[1'b0] == ($past(i_cp_wdata[5:0]) & 6'h37))
        else $error("non-secure control write lost");

    chk_low_write_read: assert property (
        s_low_write ##1 !i_cp_valid ##1 s_low_read_same
            |=> o_cp_rdata[31:7] == $past(i_cp_wdata[31:7], 3))
        else $error("low base not returned in full");

    chk_outer_attr: assert property (
        i_miss_valid |=> o_walk_outer_attr == $past(exp_attr[4:3]))
        else $error("outer walk attribute wrong");

    chk_shared_attr: assert property (
        i_miss_valid |=> o_walk_shared == $past(exp_attr[1]))
        else $error("walk shareability wrong");

    chk_inner_attr: assert property (
        i_miss_valid |=> o_walk_inner_attr == $past({exp_attr[0], exp_attr[6]}))
        else $error("inner walk attribute wrong");

    chk_low_base_trim: assert property (
        i_miss_valid && !exp_high |=> o_walk_base == $past(exp_low))
        else $error("low region base not trimmed");

    chk_high_base: assert property (
        i_miss_valid && exp_high
            |=> o_walk_base == $past({high_base_q[i_miss_secure], 14'h0000}))
        else $error("high region base wrong");

endmodule : walk_base_select

// ### walk_core_model.sv
/*
 * Core-side model of TLB miss handling: issues one-cycle misses and
 * captures the walk setup that comes back one cycle later.
 * Assumes one caller at a time and a shared rising-edge clock.
 */
`timescale 1ns/1ps
module walk_core_model
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_walk_valid,
    input  wire logic [31:0] i_walk_base,
    input  wire logic        i_walk_use_high,
    input  wire logic        i_walk_fault,
    input  wire logic        i_walk_secure,
    input  wire logic [1:0]  i_walk_outer_attr,
    input  wire logic [1:0]  i_walk_inner_attr,
    input  wire logic        i_walk_shared,
    input  wire logic        i_walk_dcache_lookup,
    output logic             o_miss_valid,
    output logic [31:0]      o_miss_virtual_address,
    output logic             o_miss_secure
);
    logic        got_valid;
    logic [31:0] got_base;
    logic [8:0]  got_flags;

    initial
    begin
        o_miss_valid           = 1'b0;
        o_miss_virtual_address = 32'h0;
        o_miss_secure          = 1'b0;
    end

    task automatic miss(input logic [31:0] va, input logic sec);
        @(posedge i_ref_clk);
        o_miss_valid           <= 1'b1;
        o_miss_virtual_address <= va;
        o_miss_secure          <= sec;
        @(posedge i_ref_clk);
        // Stale address is inverted so a late sample cannot pass by luck
        o_miss_valid           <= 1'b0;
        o_miss_virtual_address <= ~va;
        o_miss_secure          <= ~sec;
        #1;
        got_valid = i_walk_valid;
        got_base  = i_walk_base;
        got_flags = {i_walk_use_high, i_walk_fault, i_walk_secure, i_walk_outer_attr,
                     i_walk_inner_attr, i_walk_shared, i_walk_dcache_lookup};
    endtask : miss
endmodule : walk_core_model

// ### table_walk_base_select_tb.sv
/*
 * Self-checking bench for the walk base registers and region selection.
 * Assumes the core model above and the registered one-cycle answers.
 */
`timescale 1ns/1ps
module table_walk_base_select_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        lock = 1'b0;
    logic        cv = 1'b0;
    logic        cw = 1'b0;
    logic [3:0]  crn_q = 4'h0;
    logic [2:0]  opc_q = 3'h0;
    logic [3:0]  crm_q = walk_base_pkg::SEL_CRM;
    logic [31:0] wd_q = 32'h0;
    logic        pv = 1'b0;
    logic        sc = 1'b0;
    logic        ack, undef, mv, ms, wv, wh, wf, wsec, wsh, wdc;
    logic [31:0] rdata, mva, wbase;
    logic [1:0]  wout, winn;
    int          bad_count = 0;
    int          tests_run = 0;
    localparam logic [31:0] LOW_W  = 32'h8765_4fc1;
    localparam logic [31:0] HIGH_W = 32'habcd_c05b;

    walk_base_select i_walk_base_select (.i_ref_clk(clk), .i_rst(rst), .i_cp_valid(cv),
        .i_cp_write(cw), .i_cp_crn(crn_q), .i_cp_crm(crm_q),
        .i_cp_opc2(opc_q), .i_cp_wdata(wd_q), .i_cp_priv(pv), .i_cp_secure(sc),
        .i_secure_cfg_write_lock(lock), .o_cp_ack(ack), .o_cp_rdata(rdata),
        .o_cp_undef(undef), .i_miss_valid(mv), .i_miss_virtual_address(mva),
        .i_miss_secure(ms), .o_walk_valid(wv), .o_walk_base(wbase),
        .o_walk_use_high(wh), .o_walk_fault(wf), .o_walk_secure(wsec),
        .o_walk_outer_attr(wout), .o_walk_inner_attr(winn), .o_walk_shared(wsh),
        .o_walk_dcache_lookup(wdc));

    walk_core_model i_walk_core_model (.i_ref_clk(clk), .i_walk_valid(wv),
        .i_walk_base(wbase), .i_walk_use_high(wh), .i_walk_fault(wf),
        .i_walk_secure(wsec), .i_walk_outer_attr(wout), .i_walk_inner_attr(winn),
        .i_walk_shared(wsh), .i_walk_dcache_lookup(wdc), .o_miss_valid(mv),
        .o_miss_virtual_address(mva), .o_miss_secure(ms));

    initial
    begin
        forever #20 clk = ~clk;
    end

    task automatic conclude();
        if (bad_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One coprocessor access; the answer is judged one cycle after the request
    task automatic cp(input logic wr, input logic [3:0] crn, input logic [2:0] opc,
                      input logic [31:0] wd, input logic priv, input logic sec,
                      input logic exp_undef, input logic [31:0] exp_rd);
        @(posedge clk);
        cv <= 1'b1; cw <= wr; crn_q <= crn; opc_q <= opc; wd_q <= wd; pv <= priv; sc <= sec;
        @(posedge clk);
        cv <= 1'b0;
        wd_q <= ~wd;
        #1;
        check("cp ack", {31'h0, ack}, 32'h1);
        check("cp undef", {31'h0, undef}, {31'h0, exp_undef});
        if (!wr)
            check("cp rdata", rdata, exp_rd);
    endtask : cp

    task automatic miss_chk(input logic [31:0] va, input logic sec,
                            input logic [31:0] eb, input logic [2:0] ef);
        i_walk_core_model.miss(va, sec);
        check("walk valid", {31'h0, i_walk_core_model.got_valid}, 32'h1);
        check("walk base", i_walk_core_model.got_base, eb);
        check("walk sel", {29'h0, i_walk_core_model.got_flags[8:6]}, {29'h0, ef});
    endtask : miss_chk

    function automatic logic [31:0] low_trim(input logic [31:0] b, input int n);
        return b & (32'hffff_ffff << (14 - n));
    endfunction : low_trim

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        #1;
        check("ack in reset", {31'h0, ack}, 32'h0);
        check("walk in reset", {31'h0, wv}, 32'h0);
        cp(1'b0, 4'h2, 3'h2, 32'h0, 1'b1, 1'b1, 1'b0, 32'h0);
        miss_chk(32'hffff_ffff, 1'b1, 32'h0, 3'h1);
    endtask : t_reset

    task automatic t_high_regs();
        // Software keeps bits 13:7 zero and a 16KB-aligned table
        cp(1'b1, 4'h2, 3'h1, HIGH_W, 1'b1, 1'b1, 1'b0, 32'h0);
        cp(1'b0, 4'h2, 3'h1, 32'h0, 1'b1, 1'b1, 1'b0, HIGH_W);
        cp(1'b0, 4'h2, 3'h1, 32'h0, 1'b0, 1'b1, 1'b1, 32'h0);
        cp(1'b1, 4'h2, 3'h1, 32'h0, 1'b0, 1'b1, 1'b1, 32'h0);
        cp(1'b1, 4'h2, 3'h1, 32'h1234_4000, 1'b1, 1'b0, 1'b0, 32'h0);
        cp(1'b0, 4'h2, 3'h1, 32'h0, 1'b1, 1'b1, 1'b0, HIGH_W);
        cp(1'b0, 4'h2, 3'h1, 32'h0, 1'b1, 1'b0, 1'b0, 32'h1234_4000);
        cp(1'b0, 4'h3, 3'h1, 32'h0, 1'b1, 1'b1, 1'b1, 32'h0);
        cp(1'b0, 4'h2, 3'h3, 32'h0, 1'b1, 1'b1, 1'b1, 32'h0);
        @(posedge clk);
        crm_q <= 4'h1;
        cp(1'b0, 4'h2, 3'h1, 32'h0, 1'b1, 1'b1, 1'b1, 32'h0);
        @(posedge clk);
        crm_q <= walk_base_pkg::SEL_CRM;
    endtask : t_high_regs

    task automatic t_lock();
        @(posedge clk);
        lock <= 1'b1;
        cp(1'b1, 4'h2, 3'h2, 32'h3, 1'b1, 1'b1, 1'b1, 32'h0);
        cp(1'b0, 4'h2, 3'h2, 32'h0, 1'b1, 1'b1, 1'b0, 32'h0);
        cp(1'b1, 4'h2, 3'h2, 32'h12, 1'b1, 1'b0, 1'b0, 32'h0);
        cp(1'b0, 4'h2, 3'h2, 32'h0, 1'b1, 1'b0, 1'b0, 32'h12);
        @(posedge clk);
        lock <= 1'b0;
    endtask : t_lock

    task automatic t_select();
        cp(1'b1, 4'h2, 3'h0, LOW_W, 1'b1, 1'b1, 1'b0, 32'h0);
        cp(1'b0, 4'h2, 3'h0, 32'h0, 1'b1, 1'b1, 1'b0, LOW_W);
        for (int n = 0; n < 8; n++)
        begin
            // Boundary stays within zero to seven
            cp(1'b1, 4'h2, 3'h2, n, 1'b1, 1'b1, 1'b0, 32'h0);
            miss_chk(32'h1 << (31 - n), 1'b1, low_trim(LOW_W, n), 3'h1);
            if (n == 0)
                miss_chk(32'hffff_ffff, 1'b1, low_trim(LOW_W, 0), 3'h1);
            else
                miss_chk(32'h1 << (32 - n), 1'b1, 32'habcd_c000, 3'h5);
        end
    endtask : t_select

    task automatic t_attr();
        logic [31:0] w;
        for (int k = 0; k < 4; k++)
        begin
            // Outer differs from inner so a swapped field shows; shared follows inner bit 0
            w = 32'habcd_c000 | (k >> 1) | ((k & 1) << 6) | ((3 - k) << 3) | ((k >> 1) << 1);
            cp(1'b1, 4'h2, 3'h1, w, 1'b1, 1'b1, 1'b0, 32'h0);
            i_walk_core_model.miss(32'h8000_0000, 1'b1);
            check("walk attrs", {23'h0, i_walk_core_model.got_flags},
                  {23'h0, 3'h5, 2'(3 - k), k[1:0], k[1], k[0]});
        end
    endtask : t_attr

    task automatic t_disable();
        cp(1'b1, 4'h2, 3'h2, 32'h21, 1'b1, 1'b1, 1'b0, 32'h0);
        miss_chk(32'h0, 1'b1, low_trim(LOW_W, 1), 3'h1);
        miss_chk(32'h8000_0000, 1'b1, 32'habcd_c000, 3'h7);
        cp(1'b1, 4'h2, 3'h2, 32'h11, 1'b1, 1'b1, 1'b0, 32'h0);
        miss_chk(32'h0, 1'b1, low_trim(LOW_W, 1), 3'h3);
        miss_chk(32'h8000_0000, 1'b1, 32'habcd_c000, 3'h5);
        miss_chk(32'h0, 1'b0, 32'h0, 3'h2);
        miss_chk(32'hc000_0000, 1'b0, 32'h1234_4000, 3'h4);
    endtask : t_disable

    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_high_regs();
        t_lock();
        t_select();
        t_attr();
        t_disable();
        conclude();
    end

    // Hang guard: a run that outlives this counts as a mismatch
    initial
    begin
        repeat (5000) @(posedge clk);
        bad_count++;
        conclude();
    end
endmodule : table_walk_base_select_tb
